// ### drc_map.svh
// Register map, field positions, reset values and bus answers of the converter control block.
// Assumes it is included by bare name from every file that decodes or packs registers.
`ifndef DRC_MAP_SVH
`define DRC_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DRC_IDX_CONTROL   6'h00
`define DRC_IDX_RESERVED  6'h01
`define DRC_IDX_LEFT      6'h02
`define DRC_IDX_RIGHT     6'h03

// ****************************************************************
// Control register field positions
// ****************************************************************
`define DRC_BIT_ENABLE    7
`define DRC_BIT_FTEST     6
`define DRC_BIT_JUSTIFY   3
`define DRC_BIT_SIGNED    2
`define DRC_BIT_WAITHALT  1
`define DRC_BIT_PINOE     0

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define DRC_DATA_RESET    8'h00
`define DRC_CODE_RESET    8'h00
`define DRC_RESP_OKAY     2'h0
`define DRC_RESP_SLVERR   2'h2

`endif

// ### drc_pkg.sv
// Types shared by the converter control block and its two helper modules.
// Assumes nothing beyond a SystemVerilog compiler.
package drc_pkg;

  // ****************************************************************
  // Control register fields as stored
  // ****************************************************************
  typedef struct packed {
    logic enable;
    logic factoryTest;
    logic justify;
    logic signedSel;
    logic waitHalt;
    logic pinOe;
  } drc_ctrl_t;

  // ****************************************************************
  // Whole state of the bus slave and register file
  // ****************************************************************
  typedef struct packed {
    logic        awReady;
    logic        wReady;
    logic        arReady;
    logic        awHeld;
    logic [5:0]  awIndex;
    logic        wHeld;
    logic [7:0]  wData;
    logic        wLane;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
    drc_ctrl_t   ctrl;
    logic [7:0]  data;
  } drc_slave_t;

  // ****************************************************************
  // Whole state of the converter output stage
  // ****************************************************************
  typedef struct packed {
    logic [7:0] code;
    logic       powerUp;
    logic       pinDrive;
  } drc_conv_t;

endpackage

// ### drc_reg_if.sv
// Carries register contents from the register file to the output stage and read view.
// Assumes each signal has one driver: the owner drives all but rdValue, which the view drives; the others only look.
`timescale 1ns/1ps
interface drc_reg_if;
  import drc_pkg::*;

  drc_ctrl_t  ctrl;       // Stored control fields
  drc_ctrl_t  nextCtrl;   // Control fields after this edge
  logic [7:0] data;       // Stored sample
  logic [7:0] nextData;   // Sample after this edge
  logic [5:0] rdIndex;    // Register index being read
  logic [7:0] rdValue;    // Value seen at that index

  modport owner (output ctrl, nextCtrl, data, nextData, rdIndex, input rdValue);
  modport conv  (input nextCtrl, nextData);
  modport view  (input ctrl, data, rdIndex, output rdValue);
endinterface

// ### drc_read_view.sv
// Read view of the register map: what software sees at each index.
// Assumes the index is already decoded from a word-aligned bus address.
`timescale 1ns/1ps
`include "drc_map.svh"
module drc_read_view (
  drc_reg_if.view regs   // Register contents and read index
);
  import drc_pkg::*;

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  // Pure selection; the bus side registers the result
  always_comb begin
    regs.rdValue = 8'h00;
    unique case (regs.rdIndex)
      `DRC_IDX_CONTROL: begin
        regs.rdValue[`DRC_BIT_ENABLE]   = regs.ctrl.enable;
        regs.rdValue[`DRC_BIT_FTEST]    = regs.ctrl.factoryTest;
        regs.rdValue[`DRC_BIT_JUSTIFY]  = regs.ctrl.justify;
        regs.rdValue[`DRC_BIT_SIGNED]   = regs.ctrl.signedSel;
        regs.rdValue[`DRC_BIT_WAITHALT] = regs.ctrl.waitHalt;
        regs.rdValue[`DRC_BIT_PINOE]    = regs.ctrl.pinOe;
      end
      `DRC_IDX_RESERVED: regs.rdValue = 8'h00;
      `DRC_IDX_LEFT: regs.rdValue = regs.ctrl.justify ? 8'h00 : regs.data;
      `DRC_IDX_RIGHT: regs.rdValue = regs.ctrl.justify ? regs.data : 8'h00;
      default: regs.rdValue = 8'h00;
    endcase
  end
endmodule

// ### drc_conv_stage.sv
// Output stage toward the analog converter and the output pad.
// Assumes power-mode inputs are synchronous to clk and held by the system.
`timescale 1ns/1ps
`include "drc_map.svh"
module drc_conv_stage (
  input  wire logic clk,         // Bus clock
  input  wire logic rst,         // Synchronous reset, high
  input  wire logic waitMode,    // System in wait mode
  input  wire logic stopMode,    // System in stop mode
  drc_reg_if.conv   regs,        // Register values after this edge
  output logic [7:0] code,       // Converter input code
  output logic       powerUp,    // Converter powered
  output logic       pinDrive    // Pad drives the level
);
  import drc_pkg::*;

  drc_conv_t st;
  drc_conv_t next_st;
  logic      active;

  // ****************************************************************
  // Next output state
  // ****************************************************************
  // Built from the next register values so a write shows at its own edge
  always_comb begin
    next_st = st;
    active = regs.nextCtrl.enable && !stopMode && !(regs.nextCtrl.waitHalt && waitMode);
    next_st.powerUp = active;
    next_st.pinDrive = active && regs.nextCtrl.pinOe;
    if (active) begin
      if (regs.nextCtrl.signedSel) begin
        next_st.code = {~regs.nextData[7], regs.nextData[6:0]};
      end else begin
        next_st.code = regs.nextData;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // reset powers down
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{code: `DRC_CODE_RESET, powerUp: 1'b0, pinDrive: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign code     = st.code;
  assign powerUp  = st.powerUp;
  assign pinDrive = st.pinDrive;
endmodule

// ### drc_top.sv
// Control and register front end of an 8-bit single-channel converter, AXI4-Lite slave.
// Assumes power-mode and special-mode inputs are synchronous to clk; pad and analog core sit outside.
`timescale 1ns/1ps
`include "drc_map.svh"
module drc_top (
  input  wire logic        clk,             // Bus clock, 250 MHz
  input  wire logic        rst,             // Synchronous reset, high
  // Write address channel
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [7:0]  s_axi_awaddr,    // Write byte address
  input  wire logic [2:0]  s_axi_awprot,    // Protection, unused
  // Write data channel
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Byte strobes
  // Write response channel
  output logic             s_axi_bvalid,    // Response valid
  input  wire logic        s_axi_bready,    // Response ready
  output logic [1:0]       s_axi_bresp,     // Response code
  // Read address channel
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  input  wire logic [7:0]  s_axi_araddr,    // Read byte address
  input  wire logic [2:0]  s_axi_arprot,    // Protection, unused
  // Read data channel
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  // System modes
  input  wire logic        specialMode,     // Special mode, unlocks test bit
  input  wire logic        waitMode,        // System in wait mode
  input  wire logic        stopMode,        // System in stop mode
  // Converter and pad
  output logic [7:0]       dacCode,         // Code to analog converter
  output logic             dacPowerUp,      // Converter power and run
  output logic             analogOutPinOe   // Pad drive enable, else high-Z
);
  import drc_pkg::*;

  // ****************************************************************
  // State and helper instances
  // ****************************************************************
  drc_slave_t st;
  drc_slave_t next_st;
  drc_reg_if  regs ();

  // Read view decodes the address the master offers right now
  drc_read_view u_view (
    .regs (regs)
  );

  // Output stage registers the values that this edge stores
  drc_conv_stage u_conv (
    .clk      (clk),
    .rst      (rst),
    .waitMode (waitMode),
    .stopMode (stopMode),
    .regs     (regs),
    .code     (dacCode),
    .powerUp  (dacPowerUp),
    .pinDrive (analogOutPinOe)
  );

  // ****************************************************************
  // Register contents toward the helpers
  // ****************************************************************
  // Both current and next values travel, so outputs can follow a write
  assign regs.ctrl     = st.ctrl;
  assign regs.nextCtrl = next_st.ctrl;
  assign regs.data     = st.data;
  assign regs.nextData = next_st.data;
  assign regs.rdIndex  = s_axi_araddr[7:2];

  // ****************************************************************
  // Next state: bus channels and register writes
  // ****************************************************************
  always_comb begin
    next_st = st;

    // Write address: held until the paired data arrives
    if (st.awReady && s_axi_awvalid) begin
      next_st.awHeld  = 1'b1;
      next_st.awIndex = s_axi_awaddr[7:2];
    end

    // Write data: only byte lane 0 carries register bits
    if (st.wReady && s_axi_wvalid) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata[7:0];
      next_st.wLane = s_axi_wstrb[0];
    end

    // Response retires when the master takes it
    if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    // Write executes once address and data are both held
    if (st.awHeld && st.wHeld && !st.bValid) begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = `DRC_RESP_OKAY;
      unique case (st.awIndex)
        `DRC_IDX_CONTROL: begin
          if (st.wLane) begin
            next_st.ctrl.enable    = st.wData[`DRC_BIT_ENABLE];
            next_st.ctrl.justify   = st.wData[`DRC_BIT_JUSTIFY];
            next_st.ctrl.signedSel = st.wData[`DRC_BIT_SIGNED];
            next_st.ctrl.waitHalt  = st.wData[`DRC_BIT_WAITHALT];
            next_st.ctrl.pinOe     = st.wData[`DRC_BIT_PINOE];
            if (specialMode) begin
              next_st.ctrl.factoryTest = st.wData[`DRC_BIT_FTEST];
            end
          end
        end
        `DRC_IDX_RESERVED: begin
          next_st.bResp = `DRC_RESP_OKAY;
        end
        `DRC_IDX_LEFT: begin
          if (st.wLane && !st.ctrl.justify) begin
            next_st.data = st.wData;
          end
        end
        `DRC_IDX_RIGHT: begin
          if (st.wLane && st.ctrl.justify) begin
            next_st.data = st.wData;
          end
        end
        // Unmapped words answer with a slave error and change nothing
        default: begin
          next_st.bResp = `DRC_RESP_SLVERR;
        end
      endcase
    end

    // Read data retires when the master takes it
    if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // Read address: answer captured in the same cycle it is taken
    if (st.arReady && s_axi_arvalid) begin
      next_st.rValid = 1'b1;
      if (s_axi_araddr[7:2] > `DRC_IDX_RIGHT) begin
        next_st.rData = 32'h0000_0000;
        next_st.rResp = `DRC_RESP_SLVERR;
      end else begin
        next_st.rData = {24'h00_0000, regs.rdValue};
        next_st.rResp = `DRC_RESP_OKAY;
      end
    end

    // Readies come from flops; one transaction of each kind at a time
    next_st.awReady = !next_st.awHeld && !next_st.bValid;
    next_st.wReady  = !next_st.wHeld && !next_st.bValid;
    next_st.arReady = !next_st.rValid;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // no stop clearing
  // Stop and wait only gate the output stage; nothing here looks at them,
  // so register contents survive any low-power period untouched
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '{awReady:  1'b0,
              wReady:   1'b0,
              arReady:  1'b0,
              awHeld:   1'b0,
              awIndex:  6'h00,
              wHeld:    1'b0,
              wData:    8'h00,
              wLane:    1'b0,
              bValid:   1'b0,
              bResp:    `DRC_RESP_OKAY,
              rValid:   1'b0,
              rData:    32'h0000_0000,
              rResp:    `DRC_RESP_OKAY,
              ctrl:     '{enable: 1'b0, factoryTest: 1'b0, justify: 1'b0,
                          signedSel: 1'b0, waitHalt: 1'b0, pinOe: 1'b0},
              data:     `DRC_DATA_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Bus outputs
  // ****************************************************************
  // Every bus output is a field of the state register
  assign s_axi_awready = st.awReady;
  assign s_axi_wready  = st.wReady;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = st.arReady;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;
endmodule

// ### drc_top_sva.sv
// Checker of the converter control block, seeing only its top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module drc_top_sva (
  input wire logic        clk,            // Bus clock
  input wire logic        rst,            // Reset, high
  input wire logic        s_axi_awvalid,  // Write address valid
  input wire logic        s_axi_awready,  // Write address ready
  input wire logic        s_axi_wvalid,   // Write data valid
  input wire logic        s_axi_wready,   // Write data ready
  input wire logic        s_axi_bvalid,   // Response valid
  input wire logic        s_axi_bready,   // Response ready
  input wire logic [1:0]  s_axi_bresp,    // Response code
  input wire logic        s_axi_arvalid,  // Read address valid
  input wire logic        s_axi_arready,  // Read address ready
  input wire logic        s_axi_rvalid,   // Read data valid
  input wire logic        s_axi_rready,   // Read data ready
  input wire logic [31:0] s_axi_rdata,    // Read data
  input wire logic        stopMode,       // System stop
  input wire logic [7:0]  dacCode,        // Converter code
  input wire logic        dacPowerUp,     // Converter powered
  input wire logic        analogOutPinOe  // Pad drive enable
);
  // ****
  // Bus steps
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_retire_ready: assert property ($fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("readies not back after response");
  // ****
  // Converter side
  // ****
  a_pin_needs_power: assert property (analogOutPinOe |-> dacPowerUp)
    else $error("pad driven while converter off");
  a_stop_powers_down: assert property (stopMode |=> !dacPowerUp && !analogOutPinOe)
    else $error("converter on in stop");
  a_code_when_on: assert property ($changed(dacCode) |-> dacPowerUp)
    else $error("code moved while converter off");
  // Reset must be seen, so this one is never disabled
  a_reset_clears: assert property (disable iff (1'b0)
    rst |=> !dacPowerUp && !analogOutPinOe && dacCode == 8'h00 && !s_axi_bvalid)
    else $error("reset left state behind");
endmodule
bind drc_top drc_top_sva i_drc_top_sva (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .stopMode, .dacCode, .dacPowerUp, .analogOutPinOe);

// ### tb_top.sv
// Self-checking bench of the converter control block over its register bus.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "drc_map.svh"
module tb_top;
  logic        clk, rst, specialMode, waitMode, stopMode;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dacCode;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        dacPowerUp, analogOutPinOe;
  int          err_total, check_count, cycles;

  drc_top i_drc_top (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .specialMode, .waitMode, .stopMode,
    .dacCode, .dacPowerUp, .analogOutPinOe);

  // Clock, 4 ns period
  always #2 clk = ~clk;

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  // ****
  // Bus master: ready raised only after valid, so hold-off is exercised
  // ****
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] rsp);
    logic awPend;
    logic wPend;
    awPend = 1'b1;
    wPend = 1'b1;
    @(posedge clk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    while (awPend || wPend) begin
      @(posedge clk);
      if (awPend && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        awPend = 1'b0;
      end
      if (wPend && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wPend = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdreg(input logic [5:0] idx, output logic [31:0] val, output logic [1:0] rsp);
    @(posedge clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= {idx, 2'b00};
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    val = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    rdreg(idx, rd, resp);
    chk(rd, {24'h0, exp});
    chk({30'h0, resp}, {30'h0, `DRC_RESP_OKAY});
  endtask

  task automatic outchk(input logic [7:0] c, input logic p, input logic o);
    chk({22'h0, dacCode, dacPowerUp, analogOutPinOe}, {22'h0, c, p, o});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset_state;
    for (int i = 0; i < 4; i++) rdchk(6'(i), 8'h00);
    outchk(8'h00, 1'b0, 1'b0);
    $display("reset state done");
  endtask

  task automatic t_control;
    wr(`DRC_IDX_CONTROL, 8'hff, resp);
    rdchk(`DRC_IDX_CONTROL, 8'h8f);
    specialMode <= 1'b1;
    wr(`DRC_IDX_CONTROL, 8'hff, resp);
    rdchk(`DRC_IDX_CONTROL, 8'hcf);
    outchk(8'h80, 1'b1, 1'b1);
    wr(`DRC_IDX_CONTROL, 8'h00, resp);
    specialMode <= 1'b0;
    wr(`DRC_IDX_RESERVED, 8'hff, resp);
    chk({30'h0, resp}, {30'h0, `DRC_RESP_OKAY});
    rdchk(`DRC_IDX_RESERVED, 8'h00);
    wr(6'h05, 8'hff, resp);
    chk({30'h0, resp}, {30'h0, `DRC_RESP_SLVERR});
    rdreg(6'h05, rd, resp);
    chk(rd, 32'h0);
    chk({30'h0, resp}, {30'h0, `DRC_RESP_SLVERR});
    $display("control and map done");
  endtask

  task automatic t_views;
    wr(`DRC_IDX_CONTROL, 8'h81, resp);
    wr(`DRC_IDX_LEFT, 8'h5a, resp);
    outchk(8'h5a, 1'b1, 1'b1);
    rdchk(`DRC_IDX_LEFT, 8'h5a);
    wr(`DRC_IDX_RIGHT, 8'h33, resp);
    rdchk(`DRC_IDX_RIGHT, 8'h00);
    wr(`DRC_IDX_CONTROL, 8'h89, resp);
    rdchk(`DRC_IDX_LEFT, 8'h00);
    rdchk(`DRC_IDX_RIGHT, 8'h5a);
    wr(`DRC_IDX_LEFT, 8'h11, resp);
    rdchk(`DRC_IDX_RIGHT, 8'h5a);
    wr(`DRC_IDX_RIGHT, 8'h3c, resp);
    outchk(8'h3c, 1'b1, 1'b1);
    wr(`DRC_IDX_CONTROL, 8'h8d, resp);
    outchk(8'hbc, 1'b1, 1'b1);
    wr(`DRC_IDX_RIGHT, 8'h80, resp);
    outchk(8'h00, 1'b1, 1'b1);
    wr(`DRC_IDX_RIGHT, 8'h7f, resp);
    outchk(8'hff, 1'b1, 1'b1);
    // Lane 0 strobe low must leave the sample alone
    s_axi_wstrb <= 4'he;
    wr(`DRC_IDX_RIGHT, 8'h55, resp);
    s_axi_wstrb <= 4'hf;
    chk({30'h0, resp}, {30'h0, `DRC_RESP_OKAY});
    rdchk(`DRC_IDX_RIGHT, 8'h7f);
    outchk(8'hff, 1'b1, 1'b1);
    $display("data views done");
  endtask

  task automatic t_power;
    wr(`DRC_IDX_CONTROL, 8'h8b, resp);
    waitMode <= 1'b1;
    repeat (3) @(posedge clk);
    outchk(8'h7f, 1'b0, 1'b0);
    wr(`DRC_IDX_CONTROL, 8'h89, resp);
    outchk(8'h7f, 1'b1, 1'b1);
    stopMode <= 1'b1;
    repeat (3) @(posedge clk);
    outchk(8'h7f, 1'b0, 1'b0);
    rdchk(`DRC_IDX_CONTROL, 8'h89);
    rdchk(`DRC_IDX_RIGHT, 8'h7f);
    stopMode <= 1'b0;
    waitMode <= 1'b0;
    repeat (3) @(posedge clk);
    outchk(8'h7f, 1'b1, 1'b1);
    wr(`DRC_IDX_CONTROL, 8'h88, resp);
    outchk(8'h7f, 1'b1, 1'b0);
    wr(`DRC_IDX_CONTROL, 8'h09, resp);
    outchk(8'h7f, 1'b0, 1'b0);
    $display("power modes done");
  endtask

  // Main sequence, second reset in mid-run
  initial begin
    clk = 1'b0;
    {specialMode, waitMode, stopMode} = 3'b000;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    do_reset();
    t_reset_state();
    t_control();
    t_views();
    t_power();
    wr(`DRC_IDX_CONTROL, 8'h81, resp);
    do_reset();
    t_reset_state();
    close_out();
  end
endmodule
